//--- verilog/txl_regs.vh
`ifndef TXL_REGS_VH
`define TXL_REGS_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define TXL_IDX_TX_HIGH 8'h1d
`define TXL_IDX_TX_LOW 8'h1e
`define TXL_IDX_RATE 8'h1f
`define TXL_IDX_CONV 8'h20
`define TXL_IDX_IRQ_STAT 8'h30
`define TXL_IDX_IRQ_MASK 8'h31

// ----------------------------------------
// Field layout
// ----------------------------------------
`define TXL_LOW_CNT_MSB 7
`define TXL_LOW_CNT_LSB 3
`define TXL_LOW_SPLIT_MSB 2
`define TXL_LOW_SPLIT_LSB 0
`define TXL_RATE_MSB 7
`define TXL_RATE_LSB 4
`define TXL_MAX_BYTES 13'h1fff

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define TXL_IRQ_CONV 0
`define TXL_IRQ_RATE 1
`define TXL_IRQ_PAR 2
`define TXL_IRQ_W 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TXL_RST_BYTE 8'h00
`define TXL_RST_IRQ 3'h0
`define TXL_RST_WORD 32'h0000_0000
`define TXL_SPLIT_NONE 3'h0

`endif

//--- verilog/txl_irq.v
`include "txl_regs.vh"

module txl_irq (
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [`TXL_IRQ_W-1:0] event_set,
  input wire clear_we,
  input wire [`TXL_IRQ_W-1:0] clear_bits,
  input wire mask_we,
  input wire [`TXL_IRQ_W-1:0] mask_bits,
  output reg [`TXL_IRQ_W-1:0] status,
  output reg [`TXL_IRQ_W-1:0] mask,
  output reg irq
);

  reg [`TXL_IRQ_W-1:0] next_status;
  reg [`TXL_IRQ_W-1:0] next_mask;

  // ----------------------------------------
  // Sticky status, write one to clear
  // ----------------------------------------
  always @* begin
    next_status = status;
    next_mask = mask;
    if (clear_we) begin
      next_status = status & ~clear_bits;
    end
    // Set beats a clear in the same cycle, no event lost
    next_status = next_status | event_set;
    if (mask_we) begin
      next_mask = mask_bits;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      status <= `TXL_RST_IRQ;
      mask <= `TXL_RST_IRQ;
      irq <= 1'b0;
    end else if (clk_en) begin
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end

endmodule // txl_irq

//--- verilog/txl_bank.v
`include "txl_regs.vh"

module txl_bank (
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire set_default,
  input wire iso_a_mode,
  input wire anticol_ctrl,
  input wire card_idle,
  input wire wupa_issued,
  input wire rate_valid,
  input wire [3:0] rate_code,
  input wire conv_done,
  input wire [7:0] conv_data,
  output reg [7:0] tx_count_high,
  output reg [7:0] tx_count_low_split_bits,
  output reg tx_no_parity,
  output reg parity_err_event,
  output reg [7:0] detected_bit_rate_display,
  output reg [7:0] converter_result,
  output wire [`TXL_IRQ_W-1:0] irq_status,
  output wire [`TXL_IRQ_W-1:0] irq_mask,
  output wire irq
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  function split_used;
    input [7:0] low;
    begin
      split_used = (low[`TXL_LOW_SPLIT_MSB:`TXL_LOW_SPLIT_LSB]
                    != `TXL_SPLIT_NONE);
    end
  endfunction

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  wire req;
  wire accept;
  wire lane0;
  wire wr_go;
  reg [31:0] next_readdata;
  reg [7:0] next_low;

  assign req = avs_read | avs_write;
  // Access completes on the edge where waitrequest is seen low
  assign accept = req & ~avs_waitrequest;
  assign lane0 = avs_byteenable[0];
  assign wr_go = accept & avs_write & lane0;

  // One wait cycle per access keeps readdata a pure flop
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    next_readdata = `TXL_RST_WORD;
    if (hit(avs_address, `TXL_IDX_TX_HIGH)) begin
      next_readdata[7:0] = tx_count_high;
    end else if (hit(avs_address, `TXL_IDX_TX_LOW)) begin
      next_readdata[7:0] = tx_count_low_split_bits;
    end else if (hit(avs_address, `TXL_IDX_RATE)) begin
      next_readdata[7:0] = detected_bit_rate_display;
    end else if (hit(avs_address, `TXL_IDX_CONV)) begin
      next_readdata[7:0] = converter_result;
    end else if (hit(avs_address, `TXL_IDX_IRQ_STAT)) begin
      next_readdata[`TXL_IRQ_W-1:0] = irq_status;
    end else if (hit(avs_address, `TXL_IDX_IRQ_MASK)) begin
      next_readdata[`TXL_IRQ_W-1:0] = irq_mask;
    end
  end

  // Captured while waiting, so it stands at the completing edge
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      avs_readdata <= `TXL_RST_WORD;
    end else if (clk_en) begin
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // ----------------------------------------
  // Transmit length registers
  // ----------------------------------------
  always @* begin
    next_low = tx_count_low_split_bits;
    if (wr_go & hit(avs_address, `TXL_IDX_TX_LOW)) begin
      next_low = avs_writedata[7:0];
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_count_high <= `TXL_RST_BYTE;
      tx_count_low_split_bits <= `TXL_RST_BYTE;
    end else if (clk_en) begin
      if (set_default) begin
        tx_count_high <= `TXL_RST_BYTE;
        tx_count_low_split_bits <= `TXL_RST_BYTE;
      end else begin
        if (wr_go & hit(avs_address, `TXL_IDX_TX_HIGH)) begin
          tx_count_high <= avs_writedata[7:0];
        end
        tx_count_low_split_bits <= next_low;
      end
    end
  end

  // ----------------------------------------
  // Framing controls toward the transmitter
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_no_parity <= 1'b0;
      parity_err_event <= 1'b0;
    end else if (clk_en) begin
      tx_no_parity <= iso_a_mode & anticol_ctrl
                      & split_used(tx_count_low_split_bits);
      parity_err_event <= wupa_issued & anticol_ctrl & card_idle
                          & split_used(tx_count_low_split_bits);
    end
  end

  // ----------------------------------------
  // Read-only result registers
  // ----------------------------------------
  // Writes never reach these; software can only observe them
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      detected_bit_rate_display <= `TXL_RST_BYTE;
      converter_result <= `TXL_RST_BYTE;
    end else if (clk_en) begin
      if (set_default) begin
        detected_bit_rate_display <= `TXL_RST_BYTE;
        converter_result <= `TXL_RST_BYTE;
      end else begin
        if (rate_valid) begin
          detected_bit_rate_display <= {rate_code, 4'h0};
        end
        if (conv_done) begin
          converter_result <= conv_data;
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire [`TXL_IRQ_W-1:0] events;
  wire stat_we;
  wire mask_we;

  assign events = {parity_err_event, rate_valid & ~set_default,
                   conv_done & ~set_default};
  assign stat_we = wr_go & hit(avs_address, `TXL_IDX_IRQ_STAT);
  assign mask_we = wr_go & hit(avs_address, `TXL_IDX_IRQ_MASK);

  txl_irq u_irq (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .event_set(events),
    .clear_we(stat_we),
    .clear_bits(avs_writedata[`TXL_IRQ_W-1:0]),
    .mask_we(mask_we),
    .mask_bits(avs_writedata[`TXL_IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

endmodule // txl_bank

//--- tb/txl_checker.sv
`include "txl_regs.vh"
module txl_checker (
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire set_default,
  input wire iso_a_mode,
  input wire anticol_ctrl,
  input wire card_idle,
  input wire wupa_issued,
  input wire rate_valid,
  input wire [3:0] rate_code,
  input wire conv_done,
  input wire [7:0] conv_data,
  input wire [7:0] tx_count_high,
  input wire [7:0] tx_count_low_split_bits,
  input wire tx_no_parity,
  input wire parity_err_event,
  input wire [7:0] detected_bit_rate_display,
  input wire [7:0] converter_result,
  input wire [`TXL_IRQ_W-1:0] irq_status,
  input wire [`TXL_IRQ_W-1:0] irq_mask,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // Properties
  // ------------------------------
  wire split = |tx_count_low_split_bits[2:0];
  wire want_np = iso_a_mode & anticol_ctrl & split;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest && clk_en;
  endsequence
  // Lag of one cycle between status and irq is tolerated
  sequence irq_quiet;
    $stable(irq_status) && $stable(irq_mask);
  endsequence
  wait_one_a:
    assert property (req_wait |=> !avs_waitrequest) else $error("no accept");
  wait_rise_a:
    assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
    else $error("accept too long");
  conv_load_a:
    assert property (conv_done && clk_en && !set_default
      |=> converter_result == $past(conv_data)) else $error("conv lost");
  rate_load_a:
    assert property (rate_valid && clk_en && !set_default
      |=> detected_bit_rate_display == {$past(rate_code), 4'h0})
    else $error("rate lost");
  par_event_a:
    assert property (wupa_issued && clk_en && anticol_ctrl && card_idle
      && split |=> parity_err_event) else $error("no parity event");
  no_par_a:
    assert property (clk_en |=> tx_no_parity == $past(want_np))
    else $error("parity suppress wrong");
  default_clr_a:
    assert property (set_default && clk_en |=> !(tx_count_high
      | tx_count_low_split_bits | converter_result
      | detected_bit_rate_display)) else $error("defaults not restored");
  irq_level_a:
    assert property (irq_quiet [*2] |-> irq == |(irq_status & irq_mask))
    else $error("irq level wrong");
endmodule // txl_checker
bind txl_bank txl_checker u_txl_checker (.*);

//--- tb/txl_host.sv
module txl_host (
  input wire ref_clk,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  output logic [9:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {avs_read, avs_write, avs_address, avs_writedata} = '0;
  initial avs_byteenable = 4'h1;
  task xfer(input bit w, input [7:0] idx, input [7:0] d,
    input [3:0] be, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // txl_host

//--- tb/txl_bank_tb.sv
`include "txl_regs.vh"
module txl_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_b = 0, clk_en = 1, set_default = 0;
  logic iso_a_mode = 0, anticol_ctrl = 0, card_idle = 0, wupa_issued = 0;
  logic rate_valid = 0, conv_done = 0;
  logic [3:0] rate_code = 0;
  logic [7:0] conv_data = 0, h, l;
  logic [31:0] q;
  wire [9:0] avs_address;
  wire [31:0] avs_writedata, avs_readdata;
  wire [3:0] avs_byteenable;
  wire avs_read, avs_write, avs_waitrequest, tx_no_parity;
  wire parity_err_event, irq;
  wire [7:0] tx_count_high, tx_count_low_split_bits;
  wire [7:0] detected_bit_rate_display, converter_result;
  wire [`TXL_IRQ_W-1:0] irq_status, irq_mask;
  int err_count = 0, n_checks = 0;
  txl_bank u_txl_bank (.*);
  txl_host u_txl_host (.*);
  // ------------------------------
  // Tasks
  // ------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] i, input [7:0] d, input [3:0] be = 4'h1);
    u_txl_host.xfer(1'b1, i, d, be, q);
  endtask
  task rd(input [7:0] i, input [31:0] e);
    u_txl_host.xfer(1'b0, i, 8'h00, 4'h1, q);
    chk(q, e);
  endtask
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  function automatic [31:0] cnt(input [7:0] hi, input [7:0] lo);
    return {19'h0, hi, lo[7:3]};
  endfunction
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Whole run is near 210 cycles
  initial begin
    #100us;
    err_count++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(99));
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 29; i <= 32; i++) rd(i[7:0], 0);
    $display("reset values done");
    for (int k = 0; k < 9; k++) begin
      h = (k == 0) ? 8'hff : 8'($urandom);
      l = (k == 0) ? 8'hff : 8'($urandom);
      wr(8'h1d, h);
      wr(8'h1e, l);
      rd(8'h1d, h);
      rd(8'h1e, l);
      chk(cnt(tx_count_high, tx_count_low_split_bits), cnt(h, l));
    end
    $display("count registers done");
    wr(8'h1f, 8'hff);
    wr(8'h20, 8'hff);
    wr(8'h1d, ~h, 4'h0);
    rd(8'h1f, 0);
    rd(8'h20, 0);
    rd(8'h1d, h);
    rd(8'h05, 0);
    @(posedge ref_clk);
    conv_data <= $urandom;
    rate_code <= $urandom;
    conv_done <= 1'b1;
    rate_valid <= 1'b1;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    rate_valid <= 1'b0;
    rd(8'h20, conv_data);
    rd(8'h1f, {rate_code, 4'h0});
    rd(8'h30, 3);
    chk(irq, 0);
    wr(8'h31, 8'h01);
    settle;
    chk(irq, 1);
    wr(8'h30, 8'h03);
    settle;
    chk(irq, 0);
    $display("results and irq done");
    wr(8'h31, 8'h04);
    for (int s = 0; s < 2; s++) begin
      wr(8'h1e, s ? 8'h0b : 8'h08);
      {iso_a_mode, anticol_ctrl, card_idle, wupa_issued} <= 4'hf;
      @(posedge ref_clk);
      wupa_issued <= 1'b0;
      settle;
      chk(tx_no_parity, s);
      chk(irq, s);
      rd(8'h30, s ? 4 : 0);
      wr(8'h30, 8'h04);
    end
    $display("parity done");
    set_default <= 1'b1;
    @(posedge ref_clk);
    set_default <= 1'b0;
    for (int i = 29; i <= 32; i++) rd(i[7:0], 0);
    $display("defaults done");
    tally_and_finish;
  end
endmodule // txl_bank_tb
